//--- rtl/rst_pkg.sv
// Package for the reset initialization sequencer: constants and carrier types
`default_nettype none
package rst_pkg;
  // Timing in sync clock periods
  localparam int RST_IN_MIN_SYNC = 32;
  localparam int RST_POR_MIN = 32;
  localparam int RST_OUT_MIN_SYNC = 512;
  localparam int RST_SOFT_LAG_SYNC = 16;
  localparam int RST_STRAP_SETUP = 4;
  localparam int RST_STRAP_ON_SYNC = 1;
  // PLL lock bound and system clock rate
  localparam int RST_CLK_MHZ = 250;
  localparam int RST_PLL_LOCK_US = 100;
  localparam int RST_PLL_LOCK_CYC = RST_PLL_LOCK_US * RST_CLK_MHZ;
  // Strap release after hard reset assertion, ns; rounds down, at least one cycle
  localparam int RST_STRAP_OFF_NS = 4;
  localparam int RST_CLK_PERIOD_NS = 4;
  localparam int RST_STRAP_OFF_CYC =
    (RST_STRAP_OFF_NS / RST_CLK_PERIOD_NS) < 1 ? 1 : (RST_STRAP_OFF_NS / RST_CLK_PERIOD_NS);
  // Field widths
  localparam int RST_SRC_W = 3;
  localparam int RST_CNT_W = 16;
  localparam logic [2:0] RST_SRC_RESET = 3'h0;

  typedef struct packed {
    logic [RST_SRC_W-1:0] reset_source;
    logic clock_divider;
  } rst_strap_t;

  typedef enum logic [2:0] {
    RST_ST_POR, RST_ST_PLL, RST_ST_HARD, RST_ST_SOFT, RST_ST_RUN
  } rst_state_t;
endpackage
`default_nettype wire

//--- rtl/rst_sequencer.sv
// Reset initialization sequencer: reset inputs, strap capture, reset outputs
// Notes on behaviour
// - Hard or soft reset input held 32 sync periods starts the reset flow.
// - Driven hard and soft reset outputs stay asserted at least 512 sync periods.
// - Soft reset negates at least 16 sync periods after hard reset negates.
// - Stop driving strap pins within 4 ns of hard reset assertion.
// - Resume strap pin drive at least 1 sync period after hard reset negation.
// - Power-on reset flow waits the PLL lock bound of 100 us; resets requested by an input skip the wait.
// - Host mode sync period is set by the sampled divider strap.
// - Primary clock from primary input in host, PCI clock in agent mode.
`timescale 1ns/1ps
`default_nettype none
module rst_sequencer
  import rst_pkg::*;
#(
  parameter int PLL_LOCK_CYC = RST_PLL_LOCK_CYC,
  parameter int DIV_LO = 2,
  parameter int DIV_HI = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_mode,
  input wire logic primary_clock_in,
  input wire logic pci_clock_in,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_in_n,
  input wire logic soft_reset_in_n,
  input wire rst_strap_t strap_in,
  output logic hard_reset_n,
  output logic soft_reset_n,
  output logic strap_oe,
  output rst_strap_t strap_held,
  output logic sync_clock_out,
  output logic sync_tick,
  output logic reset_busy
);

  // ==========
  // Register state
  typedef struct packed {
    logic [1:0] por_s;
    logic [1:0] hrst_s;
    logic [1:0] srst_s;
    logic [1:0] host_s;
    logic [2:0] pri_s;
    logic [2:0] pci_s;
    rst_strap_t strap_s1;
    rst_strap_t strap_s2;
    rst_strap_t strap_q;
    logic [3:0] div_cnt;
    logic sync_clk;
    logic tick;
    logic [5:0] in_cnt;
    rst_state_t st;
    logic [RST_CNT_W-1:0] cnt;
    logic [RST_CNT_W-1:0] pll_cnt;
    logic hard_n;
    logic soft_n;
    logic oe;
    logic [1:0] oe_wait;
    logic busy;
  } rst_regs_t;

  rst_regs_t r;
  rst_regs_t next_r;

  // ==========
  // Helpers
  // Saturating count toward a limit
  function automatic logic [RST_CNT_W-1:0] rst_inc(input logic [RST_CNT_W-1:0] v);
    rst_inc = (v == {RST_CNT_W{1'b1}}) ? v : v + 16'h0001;
  endfunction

  // ==========
  // Input sampling and sync clock
  logic pri_rise;
  logic pci_rise;
  logic src_rise;
  logic [3:0] half_div;

  always_comb begin
    pri_rise = r.pri_s[1] & ~r.pri_s[2];
    pci_rise = r.pci_s[1] & ~r.pci_s[2];
    // Host: sync clock divided from primary by captured strap; agent: PCI clock
    src_rise = r.host_s[1] ? pri_rise : pci_rise;
    half_div = r.strap_q.clock_divider ? 4'(DIV_HI) : 4'(DIV_LO);
    next_r = r;
    next_r.por_s = {r.por_s[0], power_on_reset_n};
    next_r.hrst_s = {r.hrst_s[0], hard_reset_in_n};
    next_r.srst_s = {r.srst_s[0], soft_reset_in_n};
    next_r.host_s = {r.host_s[0], host_mode};
    next_r.pri_s = {r.pri_s[1:0], primary_clock_in};
    next_r.pci_s = {r.pci_s[1:0], pci_clock_in};
    next_r.strap_s1 = strap_in;
    next_r.strap_s2 = r.strap_s1;
    next_r.tick = 1'b0;
    if (r.host_s[1]) begin
      // Divider counts primary rises per half sync period
      if (src_rise) begin
        if (r.div_cnt >= half_div - 4'h1) begin
          next_r.div_cnt = 4'h0;
          next_r.sync_clk = ~r.sync_clk;
          next_r.tick = ~r.sync_clk;
        end else begin
          next_r.div_cnt = r.div_cnt + 4'h1;
        end
      end
    end else begin
      next_r.sync_clk = r.pci_s[1];
      next_r.tick = pci_rise;
    end
    // ==========
    // Reset sequence
    if (!r.por_s[1]) begin
      // Power-on reset: track straps, board guarantees setup and hold
      next_r.strap_q = r.strap_s2;
      next_r.st = RST_ST_POR;
      next_r.hard_n = 1'b0;
      next_r.soft_n = 1'b0;
      next_r.oe = 1'b0;
      next_r.cnt = '0;
      next_r.pll_cnt = '0;
      next_r.in_cnt = 6'h00;
    end else begin
      if (r.tick) begin
        if (!r.hrst_s[1] || !r.srst_s[1]) begin
          if (r.in_cnt != 6'h3F) begin
            next_r.in_cnt = r.in_cnt + 6'h01;
          end
        end else begin
          next_r.in_cnt = 6'h00;
        end
      end
      case (r.st)
        RST_ST_POR: begin
          next_r.st = RST_ST_PLL;
        end
        RST_ST_PLL: begin
          // Wait out the lock bound before releasing anything
          next_r.pll_cnt = rst_inc(r.pll_cnt);
          if (32'(r.pll_cnt) >= PLL_LOCK_CYC - 1) begin
            next_r.st = RST_ST_HARD;
            next_r.cnt = '0;
          end
        end
        RST_ST_HARD: begin
          // Strap pins stay released for the whole hard reset
          next_r.hard_n = 1'b0;
          next_r.soft_n = 1'b0;
          next_r.oe = 1'b0;
          if (r.tick) begin
            next_r.cnt = rst_inc(r.cnt);
          end
          if (32'(r.cnt) >= RST_OUT_MIN_SYNC) begin
            next_r.hard_n = 1'b1;
            next_r.cnt = '0;
            next_r.oe_wait = 2'h0;
            next_r.st = RST_ST_SOFT;
          end
        end
        RST_ST_SOFT: begin
          // Straps back after two ticks, soft release after sixteen
          if (r.tick) begin
            next_r.cnt = rst_inc(r.cnt);
            if (32'(r.oe_wait) <= RST_STRAP_ON_SYNC) begin
              next_r.oe_wait = r.oe_wait + 2'h1;
            end
          end
          if (32'(r.oe_wait) > RST_STRAP_ON_SYNC) begin
            next_r.oe = 1'b1;
          end
          if (32'(r.cnt) >= RST_SOFT_LAG_SYNC) begin
            next_r.soft_n = 1'b1;
            next_r.st = RST_ST_RUN;
          end
        end
        RST_ST_RUN: begin
          // Shorter request pulses are ignored
          if (32'(r.in_cnt) >= RST_IN_MIN_SYNC) begin
            next_r.hard_n = 1'b0;
            next_r.soft_n = 1'b0;
            next_r.oe = 1'b0;
            next_r.cnt = '0;
            next_r.in_cnt = 6'h00;
            next_r.st = RST_ST_HARD;
          end
        end
        default: begin
          next_r.st = RST_ST_POR;
        end
      endcase
    end
    // Busy flag registered so the output comes from a flip-flop
    next_r.busy = (next_r.st != RST_ST_RUN);
  end

  // ==========
  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.busy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========
  // Outputs
  assign hard_reset_n = r.hard_n;
  assign soft_reset_n = r.soft_n;
  assign strap_oe = r.oe;
  assign strap_held = r.strap_q;
  assign sync_clock_out = r.sync_clk;
  assign sync_tick = r.tick;
  assign reset_busy = r.busy;

endmodule
`default_nettype wire

//--- verif/reset_initialization_sequencer_tb.sv
// Bench for the reset initialization sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_initialization_sequencer_tb;
  import rst_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic host = 1'b1;
  logic hold = 1'b1;
  logic h_n = 1'b1;
  logic s_n = 1'b1;
  logic ck, por_n, hard_reset_n, soft_reset_n, strap_oe, reset_busy, tick;
  rst_strap_t strap_in = '0;
  rst_strap_t strap_held, keep;
  logic [15:0] seed = 16'h3244;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int gap;
  rst_sequencer #(.PLL_LOCK_CYC(20)) dut (.clk_sys, .sys_rst, .host_mode(host),
    .primary_clock_in(ck), .pci_clock_in(ck), .power_on_reset_n(por_n),
    .hard_reset_in_n(h_n), .soft_reset_in_n(s_n), .strap_in, .hard_reset_n,
    .soft_reset_n, .strap_oe, .strap_held, .sync_clock_out(), .sync_tick(tick),
    .reset_busy);
  rst_board_model brd (.clk_sys, .hold, .clk_pin(ck), .por_n);
  initial forever #2 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Host sync period in system cycles: primary period 4, half period 2 or 4 rises
  function automatic int exp_gap(input logic div);
    return 2 * 4 * (div ? 4 : 2);
  endfunction
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %0t %s", $time, s);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(negedge clk_sys);
    for (int k = 0; k < 30000 && reset_busy !== 1'b0; k++) @(negedge clk_sys);
    check({hard_reset_n, soft_reset_n, strap_oe, reset_busy}, 4'hE, "run");
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int m = 1; m >= 0; m--) begin
      seed = lfsr(seed);
      host <= m[0];
      keep = seed[3:0];
      strap_in <= keep;
      hold <= 1'b1;
      repeat (4) @(posedge clk_sys);
      hold <= 1'b0;
      settle();
      if (m == 1) begin
        gap = 1;
        while (tick !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        while (tick !== 1'b1) begin
          gap++;
          @(negedge clk_sys);
        end
        check(4'(gap / 4), 4'(exp_gap(keep[0]) / 4), "divide");
        @(posedge clk_sys);
      end
      strap_in <= ~keep;
      repeat (9) @(posedge clk_sys);
      check(strap_held, keep, "strap");
    end
    h_n <= 1'b0;
    repeat (4 + seed[4:0]) @(posedge clk_sys);
    h_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check({3'h0, reset_busy}, 4'h0, "short");
    @(posedge clk_sys);
    s_n <= 1'b0;
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    check({3'h0, reset_busy}, 4'h1, "long");
    @(posedge clk_sys);
    s_n <= 1'b1;
    settle();
    check(strap_held, keep, "kept");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verif/rst_board_model.sv
// Board supervisor model: input clock and power-on reset
`timescale 1ns/1ps
`default_nettype none
module rst_board_model (
  input wire logic clk_sys,
  input wire logic hold,
  output logic clk_pin,
  output logic por_n
);
  logic [7:0] h = 8'h00;
  logic [1:0] ck = 2'h0;
  assign clk_pin = ck[1];
  assign por_n = h >= 8'h28;
  always @(posedge clk_sys) begin
    ck <= ck + 2'h1;
    h <= hold ? 8'h00 : h + 8'(ck == 2'h3 && h < 8'h28);
  end
endmodule
`default_nettype wire

//--- verif/rst_sequencer_checker.sv
// Port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_sequencer_checker
  import rst_pkg::*;
#(parameter int PLL_LOCK_CYC = RST_PLL_LOCK_CYC) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic power_on_reset_n,
  input wire logic hard_reset_n,
  input wire logic soft_reset_n,
  input wire logic strap_oe,
  input wire rst_strap_t strap_held,
  input wire logic sync_tick
);
  int hc, sc, pc;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========
  // Sync ticks in and after hard reset, cycles since power-on
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hc <= 0;
      sc <= 0;
      pc <= 0;
    end else begin
      hc <= hard_reset_n ? 0 : hc + sync_tick;
      sc <= hard_reset_n ? sc + sync_tick : 0;
      pc <= power_on_reset_n ? pc + 1 : 0;
    end
  end
  chk_hard_width: assert property ($rose(hard_reset_n) |-> hc >= 512)
    else $error("hard short");
  chk_soft_inside: assert property (!hard_reset_n |-> !soft_reset_n)
    else $error("soft early");
  chk_soft_lag: assert property ($rose(soft_reset_n) |-> sc >= 16)
    else $error("soft lag");
  chk_oe_drop: assert property ($fell(hard_reset_n) |-> !strap_oe)
    else $error("oe late");
  chk_oe_inside: assert property (strap_oe |-> hard_reset_n)
    else $error("oe in reset");
  chk_oe_return: assert property ($rose(strap_oe) |-> sc >= 1)
    else $error("oe early");
  chk_pll_wait: assert property ($rose(hard_reset_n) |-> pc > PLL_LOCK_CYC)
    else $error("no lock wait");
  chk_strap_hold: assert property (pc > 6 |-> $stable(strap_held))
    else $error("strap moved");
  cover property ($rose(soft_reset_n));
  cover property ($fell(hard_reset_n) && power_on_reset_n);
  cover property ($rose(strap_oe));
endmodule
bind rst_sequencer rst_sequencer_checker #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) chk (.*);
`default_nettype wire
